//--- ssb_pkg.sv
// Package for the shadow data buffer of the second serial port: map, fields, reset values.
// How it works
// - Data location aliases receive and transmit holding.
// - Reads return received byte, pin chosen by mode.
// - No FIFO: new byte overwrites, flags overrun.
// - FIFO mode: read returns oldest receive entry.
// - Full receive FIFO drops new byte, flags overrun.
// - Written bytes go to serial or infrared out.
// - No FIFO: write clears empty, rewrites overwrite.
// - FIFO mode accepts writes up to FIFO depth.
// - Write to full transmit FIFO is discarded.
package ssb_pkg;

	// Register byte addresses on the APB bus.
	localparam logic [31:0] DATA_ADDR = 32'h50001150;
	localparam logic [31:0] CTRL_ADDR = 32'h50001300;
	localparam logic [31:0] STAT_ADDR = 32'h50001304;
	localparam logic [31:0] IRQ_STAT_ADDR = 32'h50001308;
	localparam logic [31:0] IRQ_EN_ADDR = 32'h5000130c;
	localparam logic [31:0] IRQ_CLR_ADDR = 32'h50001310;

	// Widths of the character and of the shadow data register.
	localparam int CHAR_W = 8;
	localparam int DATA_REG_W = 16;

	// Control register fields and reset value.
	localparam int CTRL_FIFO_EN_BIT = 0;
	localparam int CTRL_IR_MODE_BIT = 1;
	localparam int CTRL_W = 2;
	localparam logic [1:0] CTRL_RST = 2'h0;

	// Status register fields, mirroring the line status word positions.
	localparam int STAT_DATA_READY_BIT = 0;
	localparam int STAT_HOLD_EMPTY_BIT = 5;

	// Interrupt event bits, shared by status, enable and clear registers.
	localparam int IRQ_OVR_BIT = 0;
	localparam int IRQ_RXD_BIT = 1;
	localparam int IRQ_HOLD_EMPTY_BIT = 2;
	localparam int IRQ_W = 3;
	localparam logic [2:0] IRQ_RST = 3'h0;

	// Default FIFO depth in characters.
	localparam int FIFO_DEPTH_DEF = 16;

	// Register selected by an APB address.
	typedef enum {SEL_NONE, SEL_DATA, SEL_CTRL, SEL_STAT, SEL_ISTAT, SEL_IEN, SEL_ICLR} ssb_sel_t;

endpackage : ssb_pkg

//--- ssb_fifo.sv
// Synchronous FIFO used for both the receive and the transmit character queues.
`timescale 1ns/100ps
module ssb_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	input wire logic flush_i,
	input wire logic push_i,
	input wire logic [WIDTH-1:0] wdata_i,
	input wire logic pop_i,
	output logic [WIDTH-1:0] head_o,
	output logic full_o,
	output logic empty_o
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0] wptr_r, wptr_nxt, rptr_r, rptr_nxt;
	logic [AW:0] cnt_r, cnt_nxt;
	logic do_push, do_pop;

	// A push into a full queue or a pop from an empty one is ignored here as a second guard.
	assign do_push = push_i & (cnt_r != (AW+1)'(DEPTH));
	assign do_pop = pop_i & (cnt_r != '0);
	assign full_o = (cnt_r == (AW+1)'(DEPTH));
	assign empty_o = (cnt_r == '0);
	assign head_o = mem_r[rptr_r];

	// Pointer arithmetic wraps at the depth, which need not be a power of two; the count runs from zero up to the depth.
	always_comb begin
		wptr_nxt = wptr_r;
		rptr_nxt = rptr_r;
		cnt_nxt = cnt_r;
		if (do_push) begin
			wptr_nxt = (wptr_r == AW'(DEPTH - 1)) ? '0 : wptr_r + AW'(1);
		end
		if (do_pop) begin
			rptr_nxt = (rptr_r == AW'(DEPTH - 1)) ? '0 : rptr_r + AW'(1);
		end
		cnt_nxt = cnt_r + (AW+1)'(do_push) - (AW+1)'(do_pop);
		if (flush_i) begin
			wptr_nxt = '0;
			rptr_nxt = '0;
			cnt_nxt = '0;
		end
	end

	// Pointers are reset; the storage itself needs no reset since empty hides it.
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			wptr_r <= '0;
			rptr_r <= '0;
			cnt_r <= '0;
		end else if (ce_i) begin
			wptr_r <= wptr_nxt;
			rptr_r <= rptr_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// Storage write port.
	always_ff @(posedge clk_i) begin
		if (ce_i && do_push && !flush_i) begin
			mem_r[wptr_r] <= wdata_i;
		end
	end

endmodule : ssb_fifo

//--- ssb_irq.sv
// Sticky interrupt status with enable mask and write-one-to-clear register.
`timescale 1ns/100ps
module ssb_irq #(
	parameter int W = 3
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	input wire logic [W-1:0] set_i,
	input wire logic clr_wr_i,
	input wire logic en_wr_i,
	input wire logic [W-1:0] wdata_i,
	output logic [W-1:0] stat_o,
	output logic [W-1:0] en_o,
	output logic irq_o
);
	logic [W-1:0] stat_r, stat_nxt, en_r, en_nxt;
	logic irq_r, irq_nxt;

	// A set in the same cycle as its clear wins, so no event is lost.
	always_comb begin
		stat_nxt = stat_r;
		en_nxt = en_r;
		if (clr_wr_i) begin
			stat_nxt = stat_nxt & ~wdata_i;
		end
		stat_nxt = stat_nxt | set_i;
		if (en_wr_i) begin
			en_nxt = wdata_i;
		end
		irq_nxt = |(stat_nxt & en_nxt);
	end

	// Interrupt output is registered so it is glitch free.
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			stat_r <= '0;
			en_r <= '0;
			irq_r <= 1'b0;
		end else if (ce_i) begin
			stat_r <= stat_nxt;
			en_r <= en_nxt;
			irq_r <= irq_nxt;
		end
	end

	assign stat_o = stat_r;
	assign en_o = en_r;
	assign irq_o = irq_r;

endmodule : ssb_irq

//--- ssb_shadow_buf.sv
// Shadow receive/transmit data location of the second serial port, with APB slave.
`timescale 1ns/100ps
module ssb_shadow_buf #(
	parameter int FIFO_DEPTH = ssb_pkg::FIFO_DEPTH_DEF
) (
	input wire logic CLK_I,
	input wire logic RSTN_I,
	input wire logic CE_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [31:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	output logic [31:0] PRDATA_O,
	output logic PREADY_O,
	output logic PSLVERR_O,
	input wire logic SIN_STROBE_I,
	input wire logic [7:0] SIN_BYTE_I,
	input wire logic SIRIN_STROBE_I,
	input wire logic [7:0] SIRIN_BYTE_I,
	input wire logic TX_READY_I,
	output logic [7:0] TX_BYTE_O,
	output logic SOUT_STROBE_O,
	output logic SIROUT_STROBE_O,
	output logic DATA_READY_O,
	output logic TRANSMIT_HOLDING_EMPTY_O,
	output logic OVERRUN_O,
	output logic IRQ_O
);

	// Address decode; used for both the read and the write paths.
	function automatic ssb_pkg::ssb_sel_t decode(input logic [31:0] a);
		ssb_pkg::ssb_sel_t s;
		s = ssb_pkg::SEL_NONE;
		case (a)
			ssb_pkg::DATA_ADDR: s = ssb_pkg::SEL_DATA;
			ssb_pkg::CTRL_ADDR: s = ssb_pkg::SEL_CTRL;
			ssb_pkg::STAT_ADDR: s = ssb_pkg::SEL_STAT;
			ssb_pkg::IRQ_STAT_ADDR: s = ssb_pkg::SEL_ISTAT;
			ssb_pkg::IRQ_EN_ADDR: s = ssb_pkg::SEL_IEN;
			ssb_pkg::IRQ_CLR_ADDR: s = ssb_pkg::SEL_ICLR;
			default: s = ssb_pkg::SEL_NONE;
		endcase
		return s;
	endfunction : decode

	// Bus handshake state.
	logic pready_r, pready_nxt;
	logic pslverr_r, pslverr_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	ssb_pkg::ssb_sel_t sel;
	logic setup, wr_done, rd_done, data_wr, data_rd;

	// Control register.
	logic [ssb_pkg::CTRL_W-1:0] ctrl_r, ctrl_nxt;
	logic fifo_en, ir_mode, flush;

	// Receive path.
	logic rx_strobe;
	logic [7:0] rx_byte;
	logic [7:0] rx_hold_r, rx_hold_nxt;
	logic rx_held_r, rx_held_nxt;
	logic rx_push, rx_pop, rx_full, rx_empty;
	logic [7:0] rx_head;
	logic data_ready, overrun_ev, rx_store_ev;

	// Transmit path.
	logic [7:0] tx_hold_r, tx_hold_nxt;
	logic hold_empty_r, hold_empty_nxt;
	logic tx_push, tx_pop, tx_full, tx_empty;
	logic [7:0] tx_head;
	logic transmit_holding_empty, handoff;
	logic [7:0] tx_byte_r, tx_byte_nxt;
	logic sout_stb_r, sout_stb_nxt, sirout_stb_r, sirout_stb_nxt;

	// Status outputs and interrupt wiring.
	logic ready_out_r, hold_empty_out_r, hold_empty_d_r, ovr_r;
	logic [ssb_pkg::IRQ_W-1:0] irq_set, irq_stat, irq_en;
	logic irq;

	// Transfer phases: a write or a read takes effect only at the edge that ends the access.
	assign sel = decode(PADDR_I);
	assign setup = PSEL_I & ~PENABLE_I;
	assign wr_done = PSEL_I & PENABLE_I & pready_r & PWRITE_I;
	assign rd_done = PSEL_I & PENABLE_I & pready_r & ~PWRITE_I;
	assign data_wr = wr_done & (sel == ssb_pkg::SEL_DATA);
	assign data_rd = rd_done & (sel == ssb_pkg::SEL_DATA);

	// Mode bits; changing the FIFO enable empties both queues so stale data never mixes in.
	assign fifo_en = ctrl_r[ssb_pkg::CTRL_FIFO_EN_BIT];
	assign ir_mode = ctrl_r[ssb_pkg::CTRL_IR_MODE_BIT];
	assign flush = wr_done & (sel == ssb_pkg::SEL_CTRL) &
		(PWDATA_I[ssb_pkg::CTRL_FIFO_EN_BIT] != fifo_en);

	always_comb begin
		ctrl_nxt = ctrl_r;
		if (wr_done && sel == ssb_pkg::SEL_CTRL) begin
			ctrl_nxt = PWDATA_I[ssb_pkg::CTRL_W-1:0];
		end
	end

	// Receive source follows the mode: serial pin or infrared pin deserializer.
	assign rx_strobe = ir_mode ? SIRIN_STROBE_I : SIN_STROBE_I;
	assign rx_byte = ir_mode ? SIRIN_BYTE_I : SIN_BYTE_I;

	// Receive FIFO: a full queue keeps its entries and the new character is lost.
	assign rx_push = fifo_en & rx_strobe & ~rx_full;
	assign rx_pop = fifo_en & data_rd & ~rx_empty;

	ssb_fifo #(
		.WIDTH(ssb_pkg::CHAR_W),
		.DEPTH(FIFO_DEPTH)
	) u_rx_fifo (
		.clk_i(CLK_I),
		.rstn_i(RSTN_I),
		.ce_i(CE_I),
		.flush_i(flush),
		.push_i(rx_push),
		.wdata_i(rx_byte),
		.pop_i(rx_pop),
		.head_o(rx_head),
		.full_o(rx_full),
		.empty_o(rx_empty)
	);

	// Single holding byte when queues are off; an arrival beats a read in the same cycle.
	// The read still returns the old byte, so the new one must stay flagged as unread.
	always_comb begin
		rx_hold_nxt = rx_hold_r;
		rx_held_nxt = rx_held_r;
		if (data_rd) begin
			rx_held_nxt = 1'b0;
		end
		if (!fifo_en && rx_strobe) begin
			rx_hold_nxt = rx_byte;
			rx_held_nxt = 1'b1;
		end
		if (flush) begin
			rx_held_nxt = 1'b0;
		end
	end

	// Overrun: an unread holding byte is overwritten, or the full queue drops the arrival.
	assign overrun_ev = rx_strobe & (fifo_en ? rx_full : (rx_held_r & ~data_rd));
	assign rx_store_ev = rx_strobe & (~fifo_en | ~rx_full);
	assign data_ready = fifo_en ? ~rx_empty : rx_held_r;

	// Transmit FIFO: writes beyond the depth are dropped and the stored bytes stay intact.
	assign tx_push = fifo_en & data_wr & ~tx_full;
	assign handoff = TX_READY_I & (fifo_en ? ~tx_empty : ~hold_empty_r);
	assign tx_pop = fifo_en & handoff;

	ssb_fifo #(
		.WIDTH(ssb_pkg::CHAR_W),
		.DEPTH(FIFO_DEPTH)
	) u_tx_fifo (
		.clk_i(CLK_I),
		.rstn_i(RSTN_I),
		.ce_i(CE_I),
		.flush_i(flush),
		.push_i(tx_push),
		.wdata_i(PWDATA_I[ssb_pkg::CHAR_W-1:0]),
		.pop_i(tx_pop),
		.head_o(tx_head),
		.full_o(tx_full),
		.empty_o(tx_empty)
	);

	// Holding byte without queues: a write clears empty; a later write simply overwrites.
	// A write in the cycle of a handoff sends the old byte and keeps the new one held.
	always_comb begin
		tx_hold_nxt = tx_hold_r;
		hold_empty_nxt = hold_empty_r;
		if (!fifo_en && handoff) begin
			hold_empty_nxt = 1'b1;
		end
		if (!fifo_en && data_wr) begin
			tx_hold_nxt = PWDATA_I[ssb_pkg::CHAR_W-1:0];
			hold_empty_nxt = 1'b0;
		end
		if (flush) begin
			hold_empty_nxt = 1'b1;
		end
	end

	// Empty means the shifter has taken everything that was written.
	assign transmit_holding_empty = fifo_en ? tx_empty : hold_empty_r;

	// Byte handed to the shifter with a one-cycle strobe on the path of the current mode.
	always_comb begin
		tx_byte_nxt = tx_byte_r;
		sout_stb_nxt = 1'b0;
		sirout_stb_nxt = 1'b0;
		if (handoff && !flush) begin
			tx_byte_nxt = fifo_en ? tx_head : tx_hold_r;
			sout_stb_nxt = ~ir_mode;
			sirout_stb_nxt = ir_mode;
		end
	end

	// Interrupt events: overrun, character stored, and holding empty becoming set.
	assign irq_set[ssb_pkg::IRQ_OVR_BIT] = overrun_ev;
	assign irq_set[ssb_pkg::IRQ_RXD_BIT] = rx_store_ev;
	assign irq_set[ssb_pkg::IRQ_HOLD_EMPTY_BIT] = transmit_holding_empty & ~hold_empty_d_r;

	ssb_irq #(
		.W(ssb_pkg::IRQ_W)
	) u_irq (
		.clk_i(CLK_I),
		.rstn_i(RSTN_I),
		.ce_i(CE_I),
		.set_i(irq_set),
		.clr_wr_i(wr_done & (sel == ssb_pkg::SEL_ICLR)),
		.en_wr_i(wr_done & (sel == ssb_pkg::SEL_IEN)),
		.wdata_i(PWDATA_I[ssb_pkg::IRQ_W-1:0]),
		.stat_o(irq_stat),
		.en_o(irq_en),
		.irq_o(irq)
	);

	// Read data is captured in the setup cycle, so every access ends with no wait state.
	always_comb begin
		pready_nxt = setup;
		pslverr_nxt = setup & (sel == ssb_pkg::SEL_NONE);
		prdata_nxt = '0;
		if (setup && !PWRITE_I) begin
			case (sel)
				ssb_pkg::SEL_DATA: begin
					// Upper bits of the 16-bit data location are reserved and read as zero.
					prdata_nxt[ssb_pkg::CHAR_W-1:0] = fifo_en ? rx_head : rx_hold_r;
				end
				ssb_pkg::SEL_CTRL: begin
					prdata_nxt[ssb_pkg::CTRL_W-1:0] = ctrl_r;
				end
				ssb_pkg::SEL_STAT: begin
					// Reader must check this bit before trusting the data byte.
					prdata_nxt[ssb_pkg::STAT_DATA_READY_BIT] = data_ready;
					prdata_nxt[ssb_pkg::STAT_HOLD_EMPTY_BIT] = transmit_holding_empty;
				end
				ssb_pkg::SEL_ISTAT: begin
					prdata_nxt[ssb_pkg::IRQ_W-1:0] = irq_stat;
				end
				ssb_pkg::SEL_IEN: begin
					prdata_nxt[ssb_pkg::IRQ_W-1:0] = irq_en;
				end
				default: begin
					prdata_nxt = '0;
				end
			endcase
		end
	end

	// All state registers; CE_I low freezes everything.
	always_ff @(posedge CLK_I) begin
		if (!RSTN_I) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= '0;
			ctrl_r <= ssb_pkg::CTRL_RST;
			rx_hold_r <= '0;
			rx_held_r <= 1'b0;
			tx_hold_r <= '0;
			hold_empty_r <= 1'b1;
			tx_byte_r <= '0;
			sout_stb_r <= 1'b0;
			sirout_stb_r <= 1'b0;
			ready_out_r <= 1'b0;
			hold_empty_out_r <= 1'b1;
			hold_empty_d_r <= 1'b1;
			ovr_r <= 1'b0;
		end else if (CE_I) begin
			pready_r <= pready_nxt;
			pslverr_r <= pslverr_nxt;
			prdata_r <= prdata_nxt;
			ctrl_r <= ctrl_nxt;
			rx_hold_r <= rx_hold_nxt;
			rx_held_r <= rx_held_nxt;
			tx_hold_r <= tx_hold_nxt;
			hold_empty_r <= hold_empty_nxt;
			tx_byte_r <= tx_byte_nxt;
			sout_stb_r <= sout_stb_nxt;
			sirout_stb_r <= sirout_stb_nxt;
			ready_out_r <= data_ready;
			hold_empty_out_r <= transmit_holding_empty;
			hold_empty_d_r <= transmit_holding_empty;
			ovr_r <= overrun_ev;
		end
	end

	// Every top-level output comes from a flip-flop.
	assign PRDATA_O = prdata_r;
	assign PREADY_O = pready_r;
	assign PSLVERR_O = pslverr_r;
	assign TX_BYTE_O = tx_byte_r;
	assign SOUT_STROBE_O = sout_stb_r;
	assign SIROUT_STROBE_O = sirout_stb_r;
	assign DATA_READY_O = ready_out_r;
	assign TRANSMIT_HOLDING_EMPTY_O = hold_empty_out_r;
	assign OVERRUN_O = ovr_r;
	assign IRQ_O = irq;

endmodule : ssb_shadow_buf

//--- ssb_shadow_buf_asserts.sv
// Concurrent checks on the ports of the shadow data buffer.
`timescale 1ns/100ps
module ssb_shadow_buf_asserts (
	input wire logic CLK_I,
	input wire logic RSTN_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [31:0] PADDR_I,
	input wire logic [31:0] PRDATA_O,
	input wire logic PREADY_O,
	input wire logic PSLVERR_O,
	input wire logic SIN_STROBE_I,
	input wire logic SIRIN_STROBE_I,
	input wire logic TX_READY_I,
	input wire logic [7:0] TX_BYTE_O,
	input wire logic SOUT_STROBE_O,
	input wire logic SIROUT_STROBE_O,
	input wire logic DATA_READY_O,
	input wire logic TRANSMIT_HOLDING_EMPTY_O,
	input wire logic OVERRUN_O
);
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!RSTN_I);
	// A setup cycle, and a data write at its completing edge.
	sequence s_setup;
		PSEL_I && !PENABLE_I;
	endsequence
	sequence s_wr_data;
		PSEL_I && PENABLE_I && PREADY_O && PWRITE_I && PADDR_I == ssb_pkg::DATA_ADDR;
	endsequence
	property p_ready_next;
		s_setup |=> PREADY_O;
	endproperty
	a_ready_next: assert property (p_ready_next) else $error("no ready after setup");
	property p_ready_pulse;
		PREADY_O |=> !PREADY_O;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("ready held");
	property p_idle_zero;
		!PREADY_O |-> PRDATA_O == 32'h0 && !PSLVERR_O;
	endproperty
	a_idle_zero: assert property (p_idle_zero) else $error("bus outputs not idle");
	property p_rd_byte;
		PREADY_O && !PWRITE_I && PADDR_I == ssb_pkg::DATA_ADDR |-> PRDATA_O[31:8] == 24'h0;
	endproperty
	a_rd_byte: assert property (p_rd_byte) else $error("upper read bits set");
	property p_hold_empty_clr;
		s_wr_data |-> ##2 !TRANSMIT_HOLDING_EMPTY_O;
	endproperty
	a_hold_empty_clr: assert property (p_hold_empty_clr) else $error("empty flag kept");
	property p_dr_cause;
		$rose(DATA_READY_O) |-> $past(SIN_STROBE_I || SIRIN_STROBE_I, 2);
	endproperty
	a_dr_cause: assert property (p_dr_cause) else $error("ready without char");
	property p_ovr_cause;
		OVERRUN_O |-> $past(SIN_STROBE_I || SIRIN_STROBE_I) || $past(SIN_STROBE_I || SIRIN_STROBE_I, 2);
	endproperty
	a_ovr_cause: assert property (p_ovr_cause) else $error("overrun without char");
	property p_tx_cause;
		SOUT_STROBE_O || SIROUT_STROBE_O |-> $past(TX_READY_I) && !(SOUT_STROBE_O && SIROUT_STROBE_O);
	endproperty
	a_tx_cause: assert property (p_tx_cause) else $error("bad handoff");
	property p_tx_hold;
		!(SOUT_STROBE_O || SIROUT_STROBE_O) |-> $stable(TX_BYTE_O);
	endproperty
	a_tx_hold: assert property (p_tx_hold) else $error("tx byte moved");
endmodule : ssb_shadow_buf_asserts

//--- ssb_far_model.sv
// Remote transceiver: delivers received characters and plays the transmit shifter.
`timescale 1ns/100ps
module ssb_far_model (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic hold_i,
	input wire logic sout_stb_i,
	input wire logic sirout_stb_i,
	input wire logic [7:0] tx_byte_i,
	output logic sin_stb_o,
	output logic [7:0] sin_byte_o,
	output logic sir_stb_o,
	output logic [7:0] sir_byte_o,
	output logic tx_ready_o
);
	logic [1:0] gap_r;
	logic [7:0] got_q[$];
	logic got_ir_q[$];
	// Idle values at time zero.
	initial begin
		sin_stb_o = 1'b0;
		sir_stb_o = 1'b0;
		sin_byte_o = 8'h5a;
		sir_byte_o = 8'ha5;
	end
	// Ready is a lone pulse every fourth cycle while hold_i is low, so no double handoff.
	always @(posedge clk_i) begin
		if (!rstn_i) begin
			gap_r <= 2'h0;
			tx_ready_o <= 1'b0;
		end else begin
			gap_r <= gap_r + 2'h1;
			tx_ready_o <= !hold_i && gap_r == 2'h3;
			if (sout_stb_i || sirout_stb_i) begin
				got_q.push_back(tx_byte_i);
				got_ir_q.push_back(sirout_stb_i);
			end
		end
	end
	// One character; released lines then show the inverse of the last value.
	task automatic send(input logic [7:0] b, input logic ir);
		@(posedge clk_i);
		sin_stb_o <= !ir;
		sir_stb_o <= ir;
		sin_byte_o <= b;
		sir_byte_o <= b;
		@(posedge clk_i);
		sin_stb_o <= 1'b0;
		sir_stb_o <= 1'b0;
		sin_byte_o <= ~b;
		sir_byte_o <= ~b;
	endtask : send
endmodule : ssb_far_model

//--- tb_uart_shadow_data_buffer.sv
// Self-checking bench for the shadow data buffer and its far-side model.
`timescale 1ns/100ps
module tb_uart_shadow_data_buffer;
	localparam int D = 4;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic hold = 1'b1;
	logic [31:0] paddr = 32'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, err, sin_stb, sir_stb, tx_rdy, sout_stb, sir_out, rx_ready;
	logic hold_empty, ovr, irq;
	logic [7:0] sin_b, sir_b, tx_b, b;
	logic [7:0] exp_q[$];
	int fail_count = 0;
	int cmp_count = 0;
	int cyc = 0;
	int seed = 42;
	int n;
	int ovr_n = 0;
	ssb_shadow_buf #(.FIFO_DEPTH(D)) u_dut (.CLK_I(clk), .RSTN_I(rstn), .CE_I(1'b1),
		.PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
		.PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
		.SIN_STROBE_I(sin_stb), .SIN_BYTE_I(sin_b), .SIRIN_STROBE_I(sir_stb),
		.SIRIN_BYTE_I(sir_b), .TX_READY_I(tx_rdy), .TX_BYTE_O(tx_b), .SOUT_STROBE_O(sout_stb),
		.SIROUT_STROBE_O(sir_out), .DATA_READY_O(rx_ready),
		.TRANSMIT_HOLDING_EMPTY_O(hold_empty), .OVERRUN_O(ovr),
		.IRQ_O(irq));
	ssb_far_model u_far (.clk_i(clk), .rstn_i(rstn), .hold_i(hold), .sout_stb_i(sout_stb),
		.sirout_stb_i(sir_out), .tx_byte_i(tx_b), .sin_stb_o(sin_stb), .sin_byte_o(sin_b),
		.sir_stb_o(sir_stb), .sir_byte_o(sir_b), .tx_ready_o(tx_rdy));
	// Clock at 200 MHz.
	initial begin
		forever #2.5 clk = ~clk;
	end
	// Cut a hang short well past the expected run length.
	always @(posedge clk) begin
		cyc++;
		if (cyc > 20000) begin
			fail_count++;
			conclude();
		end
	end
	function automatic logic [31:0] word(input logic [7:0] v);
		return {24'h0, v};
	endfunction : word
	// Status word as software should see it for the given flag values.
	function automatic logic [31:0] stat_word(input logic rdy, input logic emp);
		logic [31:0] s;
		s = 32'h0;
		s[ssb_pkg::STAT_DATA_READY_BIT] = rdy;
		s[ssb_pkg::STAT_HOLD_EMPTY_BIT] = emp;
		return s;
	endfunction : stat_word
	// Overrun is a one-cycle pulse, so it is counted at every edge and checked at the end.
	always @(posedge clk) begin
		if (ovr === 1'b1) ovr_n++;
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// One APB transfer; a hung slave only ends through the timeout.
	task automatic apb(input int w, input logic [31:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w[0];
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic conclude();
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : conclude
	// Main sequence: reset, hold mode in both line modes, then FIFO mode.
	initial begin
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		chk("hold empty", hold_empty, 1);
		apb(0, ssb_pkg::DATA_ADDR + 32'h4, 0);
		chk("unmapped err", err, 1);
		$display("test reset done");
		apb(1, ssb_pkg::IRQ_EN_ADDR, 1);
		for (int ir = 0; ir < 2; ir++) begin
			apb(1, ssb_pkg::CTRL_ADDR, ir << 1);
			apb(0, ssb_pkg::CTRL_ADDR, 0);
			chk("control", rd, ir << 1);
			b = 8'($random(seed));
			u_far.send(b, ir[0]);
			n = 0;
			while (rx_ready !== 1'b1 && n < 10) begin
				@(posedge clk);
				n++;
			end
			chk("rx ready", rx_ready, 1);
			apb(0, ssb_pkg::STAT_ADDR, 0);
			chk("status full", rd, stat_word(1'b1, 1'b1));
			apb(0, ssb_pkg::DATA_ADDR, 0);
			chk("rx byte", rd, word(b));
			u_far.send(~b, ir[0]);
			u_far.send(b ^ 8'h3c, ir[0]);
			repeat (4) @(posedge clk);
			chk("irq", irq, 1);
			apb(0, ssb_pkg::DATA_ADDR, 0);
			chk("rx overwrite", rd, word(b ^ 8'h3c));
			apb(1, ssb_pkg::IRQ_CLR_ADDR, 1);
			repeat (2) @(posedge clk);
			chk("irq clr", irq, 0);
			apb(1, ssb_pkg::DATA_ADDR, word(b));
			apb(1, ssb_pkg::DATA_ADDR, word(~b));
			repeat (3) @(posedge clk);
			chk("hold empty low", hold_empty, 0);
			apb(0, ssb_pkg::STAT_ADDR, 0);
			chk("status busy", rd, stat_word(1'b0, 1'b0));
			hold <= 1'b0;
			repeat (30) @(posedge clk);
			chk("tx count", u_far.got_q.size(), 1);
			chk("tx byte", u_far.got_q[0], word(~b));
			chk("tx path", u_far.got_ir_q[0], ir[0]);
			chk("hold empty back", hold_empty, 1);
			hold <= 1'b1;
			u_far.got_q.delete();
			u_far.got_ir_q.delete();
			$display("test hold mode %0d done", ir);
		end
		apb(1, ssb_pkg::CTRL_ADDR, 1);
		for (int i = 0; i <= D; i++) begin
			b = 8'($random(seed));
			if (i < D) exp_q.push_back(b);
			apb(1, ssb_pkg::DATA_ADDR, word(b));
		end
		hold <= 1'b0;
		repeat (D * 4 + 20) @(posedge clk);
		chk("tx fifo count", u_far.got_q.size(), D);
		foreach (exp_q[i]) chk("tx fifo", u_far.got_q[i], exp_q[i]);
		exp_q.delete();
		for (int i = 0; i <= D; i++) begin
			b = 8'($random(seed));
			if (i < D) exp_q.push_back(b);
			u_far.send(b, 1'b0);
		end
		repeat (4) @(posedge clk);
		chk("fifo overrun irq", irq, 1);
		foreach (exp_q[i]) begin
			apb(0, ssb_pkg::DATA_ADDR, 0);
			chk("rx fifo", rd, word(exp_q[i]));
		end
		repeat (3) @(posedge clk);
		chk("rx ready empty", rx_ready, 0);
		chk("overrun count", ovr_n, 3);
		$display("test fifo mode done");
		conclude();
	end
endmodule : tb_uart_shadow_data_buffer
bind ssb_shadow_buf ssb_shadow_buf_asserts u_chk (.CLK_I, .RSTN_I, .PSEL_I, .PENABLE_I,
	.PWRITE_I, .PADDR_I, .PRDATA_O, .PREADY_O, .PSLVERR_O, .SIN_STROBE_I, .SIRIN_STROBE_I,
	.TX_READY_I, .TX_BYTE_O, .SOUT_STROBE_O, .SIROUT_STROBE_O, .DATA_READY_O,
	.TRANSMIT_HOLDING_EMPTY_O, .OVERRUN_O);
